// ==== dv/charger_alert_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module charger_alert_regs_tb;
    import charger_alert_pkg::*;
    localparam int SIM_DEB [4] = '{1, 1, 2, 3};
    localparam int SIM_HOLD [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
    localparam logic [7:0] CMDS [7] = '{8'h47, 8'h48, 8'h39, 8'h3c, 8'h3d, 8'h4c, 8'h4e};
    localparam logic [15:0] RST_VAL [7] = '{16'h0c00, 16'h1000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic mclk_i, nrst_i, wr_i, rd_i, adapter_present_i, system_power_monitor_enable_i, low_power_i, low_vsys_i;
    logic alert_out_o, alert_oe_o, ref_active_o, charge_enable_o, vin_loop_en_o;
    logic [7:0] cmd_i;
    logic [15:0] wdata_i, rdata_o, adapter_ma_i, battery_ma_i, rv, w;
    logic [15:0] ctrl_o [4];
    logic [2:0] buck_offset_o, boost_offset_o;
    logic [1:0] rev_offset_o, hs_short_sel_o;
    logic [10:0] c0f;
    logic [31:0] seed;
    int n_errors, total_checks, n, k;

    assign c0f = {buck_offset_o, boost_offset_o, rev_offset_o, hs_short_sel_o, vin_loop_en_o};

    charger_alert_regs #(.WDOG_CYC(20), .DEB_US(SIM_DEB), .HOLD_US(SIM_HOLD)) charger_alert_regs_inst (
        .mclk_i, .nrst_i, .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .adapter_ma_i, .battery_ma_i,
        .adapter_present_i, .system_power_monitor_enable_i, .low_power_i, .low_vsys_i, .alert_out_o, .alert_oe_o,
        .ref_active_o, .charge_enable_o, .buck_offset_o, .boost_offset_o, .rev_offset_o, .hs_short_sel_o,
        .vin_loop_en_o, .ctrl1_o(ctrl_o[0]), .ctrl2_o(ctrl_o[1]), .ctrl3_o(ctrl_o[2]), .ctrl4_o(ctrl_o[3])
    );

    smbus_host_model smbus_host_model_inst (
        .mclk_i, .wr_o(wr_i), .rd_o(rd_i), .cmd_o(cmd_i), .wdata_o(wdata_i), .rdata_i(rdata_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction : rnd

    function automatic logic [15:0] exp_reg(input logic [7:0] c, input logic [15:0] d);
        logic [5:0] f;
        f = (c == CMD_AC_ALERT) ? d[12:7] : d[13:8];
        if (f > 6'h32) f = 6'h32;
        case (c)
            CMD_AC_ALERT: exp_reg = {3'h0, f, 7'h00};
            CMD_DC_ALERT: exp_reg = {2'h0, f, 8'h00};
            CMD_CTRL0: exp_reg = d & 16'hfffc;
            default: exp_reg = d;
        endcase
    endfunction : exp_reg

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_n(input int c, input int tol);
        total_checks++;
        if (n < c - tol || n > c + tol) begin
            n_errors++;
            $display("[ERR] cycle count expected %0d seen %0d", c, n);
        end
    endtask : chk_n

    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        smbus_host_model_inst.read_word(c, rv);
        chk("read word", e, rv);
    endtask : rd_chk

    task automatic wr_rd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
        smbus_host_model_inst.write_word(c, d);
        rd_chk(c, e);
    endtask : wr_rd

    task automatic wait_lvl(input bit sel, input logic v, input int lim);
        n = 0;
        while ((sel ? charge_enable_o : alert_oe_o) !== v && n < lim) begin
            @(posedge mclk_i);
            n++;
        end
    endtask : wait_lvl

    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (40000) @(posedge mclk_i);
        n_errors++;
        complete_run();
    end

    initial begin
        seed = 32'h5de92c94;
        n_errors = 0;
        total_checks = 0;
        nrst_i = 1'b0;
        {adapter_present_i, system_power_monitor_enable_i, low_power_i, low_vsys_i} = 4'h0;
        adapter_ma_i = 16'h0000;
        battery_ma_i = 16'h0000;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        #1;
        chk("reset pins", 16'h0003, {alert_out_o, alert_oe_o, ref_active_o, charge_enable_o, vin_loop_en_o});
        for (int i = 0; i < 7; i++) rd_chk(CMDS[i], RST_VAL[i]);
        wr_rd(CMD_AC_ALERT, 16'hffff, 16'h1900);
        wr_rd(CMD_DC_ALERT, 16'hffff, 16'h3200);
        wr_rd(CMD_AC_ALERT, 16'h197f, 16'h1900);
        wr_rd(CMD_DC_ALERT, 16'hf1ff, 16'h3100);
        wr_rd(CMD_CTRL0, 16'hffff, 16'hfffc);
        wr_rd(8'h20, 16'hffff, 16'h0000);
        for (int i = 0; i < 60; i++) begin
            k = rnd() % 7;
            w = 16'(rnd());
            wr_rd(CMDS[k], w, exp_reg(CMDS[k], w));
            if (k == 2) chk("ctrl0 fields", {5'h00, w[15:8], w[6:5], ~w[2]}, {5'h00, c0f});
            if (k > 2) chk("ctrl word", w, ctrl_o[k - 3]);
        end
        smbus_host_model_inst.write_word(CMD_CTRL0, 16'h0000);
        smbus_host_model_inst.write_word(CMD_AC_ALERT, 16'h0080);
        adapter_present_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        for (int i = 0; i < 2; i++) begin
            smbus_host_model_inst.write_word(CMD_CTRL2, {5'h00, (i == 1) ? 5'b11010 : 5'b00000, 6'h00});
            adapter_ma_i <= (i == 0) ? 16'd129 : 16'd129 + 16'(rnd() & 32'hfff);
            wait_lvl(1'b0, 1'b1, 2000);
            chk_n(SIM_DEB[i * 3] * 200 + 3, 4);
            adapter_ma_i <= 16'h0000;
            wait_lvl(1'b0, 1'b0, 5000);
            chk_n(SIM_HOLD[i * 2] * 200, 4);
        end
        chk("charge stopped", 16'h0000, charge_enable_o);
        smbus_host_model_inst.write_word(CMD_CHARGE_CURRENT, 16'(rnd()));
        wait_lvl(1'b1, 1'b1, 4);
        chk_n(1, 1);
        wait_lvl(1'b1, 1'b0, 100);
        chk_n(20, 3);
        smbus_host_model_inst.write_word(CMD_CHARGE_VOLTAGE, 16'(rnd()));
        smbus_host_model_inst.write_word(CMD_CTRL0, 16'h0080);
        repeat (60) @(posedge mclk_i);
        chk("timeout off", 16'h0001, charge_enable_o);
        adapter_present_i <= 1'b0;
        smbus_host_model_inst.write_word(CMD_CTRL0, 16'h0098);
        low_power_i <= 1'b1;
        battery_ma_i <= 16'd6001;
        repeat (300) @(posedge mclk_i);
        smbus_host_model_inst.read_word(CMD_INFO, rv);
        chk("ref idle", 16'h0000, {rv[15], ref_active_o, alert_oe_o});
        system_power_monitor_enable_i <= 1'b1;
        wait_lvl(1'b0, 1'b1, 2000);
        chk_n(608, 6);
        smbus_host_model_inst.read_word(CMD_INFO, rv);
        chk("ref on", 16'h0003, {rv[15], ref_active_o});
        battery_ma_i <= 16'h0000;
        wait_lvl(1'b0, 1'b0, 2000);
        low_vsys_i <= 1'b1;
        wait_lvl(1'b0, 1'b1, 3000);
        chk_n(2007, 6);
        low_vsys_i <= 1'b0;
        complete_run();
    end
endmodule : charger_alert_regs_tb
`default_nettype wire

// ==== dv/smbus_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire logic mclk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] cmd_o,
    output logic [15:0] wdata_o,
    input wire logic [15:0] rdata_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        cmd_o = 8'h00;
        wdata_o = 16'h0000;
    end

    // Whole-word write; the released bus shows inverted values so stale data never looks valid.
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge mclk_i);
        wr_o <= 1'b1;
        cmd_o <= cmd;
        wdata_o <= data;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        cmd_o <= ~cmd;
        wdata_o <= ~data;
    endtask : write_word

    task automatic read_word(input logic [7:0] cmd, output logic [15:0] data);
        @(posedge mclk_i);
        rd_o <= 1'b1;
        cmd_o <= cmd;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        cmd_o <= ~cmd;
        @(posedge mclk_i);
        data = rdata_i;
    endtask : read_word
endmodule : smbus_host_model
`default_nettype wire

// ==== verilog/alert_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface alert_if;
    import charger_alert_pkg::*;
    logic trip;
    logic [CNT_W-1:0] debounce_cyc;
    logic [CNT_W-1:0] hold_cyc;
    logic alert;
    modport source (output trip, output debounce_cyc, output hold_cyc, input alert);
    modport timer (input trip, input debounce_cyc, input hold_cyc, output alert);
endinterface : alert_if
`default_nettype wire

// ==== verilog/alert_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module alert_timer (
    input wire logic mclk_i,
    input wire logic nrst_i,
    alert_if.timer port
);
    import charger_alert_pkg::*;
    alert_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;

    // Debounce the trip, then hold the alert for at least the minimum time.
    always_comb begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        unique case (state)
            A_IDLE: begin
                next_cnt = '0;
                if (port.trip) begin
                    next_state = A_DEB;
                end
            end
            A_DEB: begin
                if (!port.trip) begin
                    next_state = A_IDLE;
                    next_cnt = '0;
                end else if (next_cnt >= port.debounce_cyc) begin
                    next_state = A_HOLD;
                    next_cnt = '0;
                end
            end
            A_HOLD: begin
                if (cnt >= port.hold_cyc - 1'b1 && !port.trip) begin
                    next_state = A_IDLE;
                    next_cnt = '0;
                end else if (cnt >= port.hold_cyc) begin
                    next_cnt = cnt;
                end
            end
            default: begin
                next_state = A_IDLE;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= A_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign port.alert = (state == A_HOLD);

    chk_alert_hold_min: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $fell(port.alert) |-> $past(cnt) >= $past(port.hold_cyc) - 1'b1)
        else $error("alert released before its minimum hold");
    chk_alert_needs_trip: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(port.alert) |-> $past(port.trip) && $past(state) == A_DEB)
        else $error("alert rose without a debounced trip");
endmodule : alert_timer
`default_nettype wire

// ==== verilog/bus_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_watchdog #(
    parameter longint TIMEOUT_CYC = charger_alert_pkg::WDOG_DEFAULT_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic kick_i,
    output logic expired_o
);
    import charger_alert_pkg::*;
    localparam logic [WDOG_W-1:0] LIMIT = WDOG_W'(TIMEOUT_CYC - 1);
    logic [WDOG_W-1:0] cnt, next_cnt;
    logic next_expired;

    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (64'd1 << WDOG_W)) begin : g_bad
        $error("bus_watchdog timeout out of range");
    end

    // A ceiling write restarts the count and clears an expiry.
    always_comb begin
        next_cnt = cnt;
        next_expired = expired_o;
        if (kick_i || !run_i) begin
            next_cnt = '0;
        end else if (cnt < LIMIT) begin
            next_cnt = cnt + 1'b1;
        end
        if (kick_i) begin
            next_expired = 1'b0;
        end
        if (run_i && !kick_i && cnt == LIMIT) begin
            next_expired = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= '0;
            expired_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            expired_o <= next_expired;
        end
    end

    chk_wdog_expiry_cause: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(expired_o) |-> $past(run_i) && $past(cnt) == LIMIT)
        else $error("watchdog expired without a full idle count");
endmodule : bus_watchdog
`default_nettype wire

// ==== verilog/charger_alert_pkg.sv ====
`default_nettype none
package charger_alert_pkg;
    localparam int REG_W = 16;
    localparam int FIELD_W = 6;
    localparam int CNT_W = 32;
    localparam int WDOG_W = 40;
    localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_CTRL0 = 8'h39;
    localparam logic [7:0] CMD_INFO = 8'h3a;
    localparam logic [7:0] CMD_CTRL1 = 8'h3c;
    localparam logic [7:0] CMD_CTRL2 = 8'h3d;
    localparam logic [7:0] CMD_AC_ALERT = 8'h47;
    localparam logic [7:0] CMD_DC_ALERT = 8'h48;
    localparam logic [7:0] CMD_CTRL3 = 8'h4c;
    localparam logic [7:0] CMD_CTRL4 = 8'h4e;
    localparam int AC_LSB = 7;
    localparam int DC_LSB = 8;
    localparam logic [FIELD_W-1:0] FIELD_MAX = 6'h32;
    localparam logic [15:0] AC_RESET = 16'h0c00;
    localparam logic [15:0] DC_RESET = 16'h1000;
    localparam logic [15:0] CTRL0_RESET = 16'h0000;
    localparam logic [15:0] CTRL0_MASK = 16'hfffc;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int C0_BUCK_LSB = 13;
    localparam int C0_BOOST_LSB = 10;
    localparam int C0_REV_LSB = 8;
    localparam int C0_WDOG_OFF = 7;
    localparam int C0_HS_LSB = 5;
    localparam int C0_LP_LSB = 3;
    localparam int C0_VIN_OFF = 2;
    localparam int C2_HOLD_LSB = 6;
    localparam int C2_DEB_LSB = 9;
    localparam int INFO_REF_BIT = 15;
    localparam logic [15:0] LP_THRESH_MA [4] = '{16'h2ee0, 16'h2710, 16'h1f40, 16'h1770};
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;
    localparam int LOW_VSYS_DEB_US = 10;
    localparam int LOW_VSYS_DEB_CYC = LOW_VSYS_DEB_US * CYC_PER_US;
    localparam longint WDOG_TIMEOUT_S = 175;
    localparam longint WDOG_DEFAULT_CYC = WDOG_TIMEOUT_S * 64'd1000000000000 / CLK_PERIOD_PS;
    localparam int DEB_US_DEFAULT [4] = '{10, 100, 500, 1000};
    localparam int HOLD_US_DEFAULT [8] = '{10, 100, 500, 1000, 2000, 5000, 10000, 20000};

    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_DEB = 2'b01,
        A_HOLD = 2'b11
    } alert_state_t;

    function automatic logic [FIELD_W-1:0] clamp_field(input logic [FIELD_W-1:0] f);
        clamp_field = (f > FIELD_MAX) ? FIELD_MAX : f;
    endfunction : clamp_field

    function automatic logic [CNT_W-1:0] us_to_cyc(input int us);
        int c;
        c = us * CYC_PER_US;
        us_to_cyc = (c < 1) ? CNT_W'(1) : CNT_W'(c);
    endfunction : us_to_cyc
endpackage : charger_alert_pkg
`default_nettype wire

// ==== verilog/charger_alert_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Adapter alert threshold resets to 0x0c00 and reads back.
// - Adapter threshold field is bits 12:7, 128mA per LSB; others unused.
// - Adapter threshold field clamps to code 110010, 6400mA.
// - Battery threshold keeps valid bits only and clamps to code 110010.
// - Battery discharge threshold resets to 0x1000 and reads back.
// - Battery threshold field is bits 13:8, 256mA per LSB; others unused.
// - Overcurrent alert asserts after the debounce chosen by control word two 10:9.
// - Asserted alert holds for the minimum chosen by control word two 8:6.
// - Low system voltage alert uses a fixed 10us debounce.
// - Battery-only low-power threshold comes from control word zero 4:3.
// - Discharge compare needs system power monitor unless adapter is present.
// - Information status bit 15 shows comparator reference active.
// - Control word zero 15:13 sets forward buck comparator offset.
// - Control word zero 12:10 sets boost comparator offset, same coding.
// - Control word zero 9:8 sets reverse buck comparator offset.
// - With adapter and timeout on, 175s without ceiling writes ends charging.
// - A ceiling write after timeout enables charging again.
// - Control word zero bit 7 low enables the bus timeout.
// - Control word zero 6:5 selects high-side FET short threshold.
// - Control word zero bit 2 low enables input regulation loop; 1:0 unused.
module charger_alert_regs #(
    parameter longint WDOG_CYC = charger_alert_pkg::WDOG_DEFAULT_CYC,
    parameter int DEB_US [4] = charger_alert_pkg::DEB_US_DEFAULT,
    parameter int HOLD_US [8] = charger_alert_pkg::HOLD_US_DEFAULT
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] cmd_i,
    input wire logic [charger_alert_pkg::REG_W-1:0] wdata_i,
    output logic [charger_alert_pkg::REG_W-1:0] rdata_o,
    input wire logic [15:0] adapter_ma_i,
    input wire logic [15:0] battery_ma_i,
    input wire logic adapter_present_i,
    input wire logic system_power_monitor_enable_i,
    input wire logic low_power_i,
    input wire logic low_vsys_i,
    output logic alert_out_o,
    output logic alert_oe_o,
    output logic ref_active_o,
    output logic charge_enable_o,
    output logic [2:0] buck_offset_o,
    output logic [2:0] boost_offset_o,
    output logic [1:0] rev_offset_o,
    output logic [1:0] hs_short_sel_o,
    output logic vin_loop_en_o,
    output logic [15:0] ctrl1_o,
    output logic [15:0] ctrl2_o,
    output logic [15:0] ctrl3_o,
    output logic [15:0] ctrl4_o
);
    import charger_alert_pkg::*;

    localparam int NPIN = 4;

    for (genvar i = 0; i < 4; i++) begin : g_deb_chk
        if (DEB_US[i] < 1) begin : g_bad
            $error("debounce time must be at least 1us");
        end
    end
    for (genvar i = 0; i < 8; i++) begin : g_hold_chk
        if (HOLD_US[i] < 1) begin : g_bad
            $error("hold time must be at least 1us");
        end
    end

    logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin, next_pin;
    logic adapter_present, system_power_monitor_enable, low_power, low_vsys;

    logic [15:0] ac_reg, next_ac_reg;
    logic [15:0] dc_reg, next_dc_reg;
    logic [15:0] ctrl0, next_ctrl0;
    logic [15:0] ctrl1, next_ctrl1;
    logic [15:0] ctrl2, next_ctrl2;
    logic [15:0] ctrl3, next_ctrl3;
    logic [15:0] ctrl4, next_ctrl4;
    logic [15:0] next_rdata;
    logic ref_active, next_ref_active;
    logic next_alert_oe;
    logic ac_trip, dc_trip;
    logic [15:0] ac_thresh_ma, dc_thresh_ma;
    logic ceiling_kick, wdog_run, wdog_expired;
    logic [CNT_W-1:0] vsys_age, next_vsys_age;

    alert_if oc_if ();
    alert_if vsys_if ();

    assign pin_raw = {low_vsys_i, low_power_i, system_power_monitor_enable_i, adapter_present_i};

    // Pins pass three flops; a change is taken once the last two agree.
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            next_pin[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin[i];
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin <= next_pin;
        end
    end

    assign adapter_present = pin[0];
    assign system_power_monitor_enable = pin[1];
    assign low_power = pin[2];
    assign low_vsys = pin[3];

    // Register writes; reserved bits are masked and threshold fields clamped.
    always_comb begin
        next_ac_reg = ac_reg;
        next_dc_reg = dc_reg;
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_ctrl3 = ctrl3;
        next_ctrl4 = ctrl4;
        if (wr_i) begin
            unique case (cmd_i)
                CMD_AC_ALERT: begin
                    next_ac_reg = 16'(clamp_field(wdata_i[AC_LSB +: FIELD_W])) << AC_LSB;
                end
                CMD_DC_ALERT: begin
                    next_dc_reg = 16'(clamp_field(wdata_i[DC_LSB +: FIELD_W])) << DC_LSB;
                end
                CMD_CTRL0: begin
                    next_ctrl0 = wdata_i & CTRL0_MASK;
                end
                CMD_CTRL1: begin
                    next_ctrl1 = wdata_i;
                end
                CMD_CTRL2: begin
                    next_ctrl2 = wdata_i;
                end
                CMD_CTRL3: begin
                    next_ctrl3 = wdata_i;
                end
                CMD_CTRL4: begin
                    next_ctrl4 = wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Reads return the register content one cycle after the strobe.
    always_comb begin
        next_rdata = rdata_o;
        if (rd_i) begin
            unique case (cmd_i)
                CMD_AC_ALERT: next_rdata = ac_reg;
                CMD_DC_ALERT: next_rdata = dc_reg;
                CMD_CTRL0: next_rdata = ctrl0;
                CMD_CTRL1: next_rdata = ctrl1;
                CMD_CTRL2: next_rdata = ctrl2;
                CMD_CTRL3: next_rdata = ctrl3;
                CMD_CTRL4: next_rdata = ctrl4;
                CMD_INFO: next_rdata = 16'(ref_active) << INFO_REF_BIT;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ac_reg <= AC_RESET;
            dc_reg <= DC_RESET;
            ctrl0 <= CTRL0_RESET;
            ctrl1 <= CTRL_RESET;
            ctrl2 <= CTRL_RESET;
            ctrl3 <= CTRL_RESET;
            ctrl4 <= CTRL_RESET;
            rdata_o <= 16'h0000;
        end else begin
            ac_reg <= next_ac_reg;
            dc_reg <= next_dc_reg;
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            ctrl3 <= next_ctrl3;
            ctrl4 <= next_ctrl4;
            rdata_o <= next_rdata;
        end
    end

    assign buck_offset_o = ctrl0[C0_BUCK_LSB +: 3];
    assign boost_offset_o = ctrl0[C0_BOOST_LSB +: 3];
    assign rev_offset_o = ctrl0[C0_REV_LSB +: 2];
    assign hs_short_sel_o = ctrl0[C0_HS_LSB +: 2];
    assign vin_loop_en_o = !ctrl0[C0_VIN_OFF];
    assign ctrl1_o = ctrl1;
    assign ctrl2_o = ctrl2;
    assign ctrl3_o = ctrl3;
    assign ctrl4_o = ctrl4;

    // Threshold compare; low-power battery-only mode uses the coarse table.
    assign ac_thresh_ma = ac_reg;
    assign dc_thresh_ma = (!adapter_present && low_power) ? LP_THRESH_MA[ctrl0[C0_LP_LSB +: 2]] : dc_reg;
    assign next_ref_active = adapter_present || system_power_monitor_enable;
    assign ac_trip = adapter_present && (adapter_ma_i > ac_thresh_ma);
    assign dc_trip = ref_active && (battery_ma_i > dc_thresh_ma);

    assign oc_if.trip = ac_trip || dc_trip;
    assign oc_if.debounce_cyc = us_to_cyc(DEB_US[ctrl2[C2_DEB_LSB +: 2]]);
    assign oc_if.hold_cyc = us_to_cyc(HOLD_US[ctrl2[C2_HOLD_LSB +: 3]]);
    assign vsys_if.trip = low_vsys;
    assign vsys_if.debounce_cyc = CNT_W'(LOW_VSYS_DEB_CYC);
    assign vsys_if.hold_cyc = oc_if.hold_cyc;

    alert_timer u_oc_timer (.mclk_i(mclk_i), .nrst_i(nrst_i), .port(oc_if.timer));
    alert_timer u_vsys_timer (.mclk_i(mclk_i), .nrst_i(nrst_i), .port(vsys_if.timer));

    assign next_alert_oe = oc_if.alert || vsys_if.alert;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_active <= 1'b0;
            alert_oe_o <= 1'b0;
        end else begin
            ref_active <= next_ref_active;
            alert_oe_o <= next_alert_oe;
        end
    end

    assign alert_out_o = 1'b0;
    assign ref_active_o = ref_active;

    assign ceiling_kick = wr_i && (cmd_i == CMD_CHARGE_VOLTAGE || cmd_i == CMD_CHARGE_CURRENT);
    assign wdog_run = adapter_present && !ctrl0[C0_WDOG_OFF];

    bus_watchdog #(.TIMEOUT_CYC(WDOG_CYC)) u_wdog (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .run_i(wdog_run),
        .kick_i(ceiling_kick),
        .expired_o(wdog_expired)
    );

    assign charge_enable_o = !wdog_expired;

    // Counts how long low system voltage has stood, so its fixed debounce can be checked.
    always_comb begin
        next_vsys_age = '0;
        if (low_vsys) begin
            next_vsys_age = (vsys_age == '1) ? vsys_age : vsys_age + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vsys_age <= '0;
        end else begin
            vsys_age <= next_vsys_age;
        end
    end

    sequence s_ac_write;
        wr_i && cmd_i == CMD_AC_ALERT;
    endsequence
    sequence s_dc_write;
        wr_i && cmd_i == CMD_DC_ALERT;
    endsequence
    sequence s_info_read;
        rd_i && cmd_i == CMD_INFO;
    endsequence

    chk_ac_store_clamp: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_ac_write |=> ac_reg == 16'(clamp_field($past(wdata_i[AC_LSB +: FIELD_W]))) << AC_LSB)
        else $error("adapter threshold not stored clamped");
    chk_ac_field_bound: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ac_reg[AC_LSB +: FIELD_W] <= FIELD_MAX && ac_reg[6:0] == 7'h00 && ac_reg[15:13] == 3'h0)
        else $error("adapter threshold holds an illegal value");
    chk_dc_store_clamp: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_dc_write |=> dc_reg == 16'(clamp_field($past(wdata_i[DC_LSB +: FIELD_W]))) << DC_LSB)
        else $error("discharge threshold not stored clamped");
    chk_ctrl0_unused: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ctrl0[1:0] == 2'h0)
        else $error("control word zero unused bits set");
    chk_info_ref_bit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_info_read |=> rdata_o == (16'($past(ref_active)) << INFO_REF_BIT))
        else $error("information status does not show reference state");
    chk_ref_adapter: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        adapter_present |=> ref_active)
        else $error("reference inactive while adapter present");
    chk_wdog_rearm: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ceiling_kick ##1 !ceiling_kick |-> charge_enable_o)
        else $error("ceiling write did not enable charging");
    chk_wdog_disabled: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ctrl0[C0_WDOG_OFF] && charge_enable_o |=> charge_enable_o)
        else $error("charging ended while timeout disabled");
    chk_lp_select: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !adapter_present && low_power |-> dc_thresh_ma == 16'd12000 - 16'd2000 * 16'(ctrl0[C0_LP_LSB +: 2]))
        else $error("low-power discharge threshold not selected");
    chk_rdata_holds: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !rd_i |=> $stable(rdata_o))
        else $error("read data changed without a read");
    chk_charge_stop_cause: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $fell(charge_enable_o) |-> $past(wdog_run) && !$past(ceiling_kick))
        else $error("charging ended without a running timeout");
    chk_vsys_debounce: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(vsys_if.alert) |-> $past(vsys_age) == CNT_W'(LOW_VSYS_DEB_CYC))
        else $error("low system voltage alert not debounced by the fixed time");
endmodule : charger_alert_regs
`default_nettype wire
